// ==== rtl/bmc_config_regs.sv ====
/*
 Three configuration registers of a sensorless BLDC driver behind an APB slave, with decoded
 fields and derived values for the motor-control sequencer.
 Assumes sequencer inputs are on clk_sys; the master follows APB ordering.
*/
// Design decision made here: the APB interface to the registers.
`include "bmc_regs.svh"

// Contract
// - the back-EMF constant is the 4-bit significand shifted left by the 3-bit shift count.
// - the advance time is the 4-bit advance value shifted left by the 3-bit advance shift.
// - mode 0 keeps a fixed advance, mode 1 scales it by (supply minus back-EMF) over supply.
// - bit 15 of the constant/advance register reads as zero and software leaves it alone.
// - the stationary field picks a 80, 160, 320 or 640 ms window without zero crossing.
// - the brake level bit selects a 24 mA or 48 mA brake current threshold.
// - the hysteresis bit selects about 10 mV or 20 mV on the back-EMF comparator.
// - initial speed detection runs only while its enable bit is set.
// - reverse drive is applied only while its enable bit is set.
// - the reverse/brake field selects 6.3, 13, 26 or 51 Hz as start speed.
// - one 2-bit field selects both the open-loop current and the align current.
// - the 3-bit ramp field sets the open-loop current ramp-up rate.
// - brake code 000 disables braking, other codes select the brake-done time.
// - the registers sit at indices 0x91 to 0x93 and reset to zero.
// - the range bit picks the fast or slow table for both acceleration fields.
// - the handover threshold is n x 0.8 Hz with top bit 0, (n+1) x 12.8 Hz with top bit 1.
module bmc_config_regs
   import bmc_pkg::*;
#(
   parameter int AW           = 12,
   parameter int STAT_WIN_CYC = `BMC_STAT_WIN_MS * (`BMC_CLK_HZ / 1000)
)
(
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          zeroCross,
   input  wire logic          speedDetectRequest,
   input  wire logic          reverseDriveRequest,
   input  wire logic [7:0]    supplyLevel,
   input  wire logic [7:0]    bemfLevel,
   output logic      [10:0]   emfConstant,
   output logic      [10:0]   advanceTime,
   output logic      [10:0]   effectiveAdvance,
   output logic               advanceModeSel,
   output logic      [1:0]    stationaryJudgeThreshold,
   output logic               brakeCurrentLevelSel,
   output logic               comparatorHysteresisSel,
   output logic               speedDetectEnable,
   output logic               reverseDriveEnable,
   output logic      [1:0]    reverseBrakeThreshold,
   output logic      [1:0]    openloopAlignCurrent,
   output logic      [2:0]    openloopCurrentRamp,
   output logic      [2:0]    brakeDoneTime,
   output logic               brakeActiveFlag,
   output logic               accelRangeSelA,
   output logic      [2:0]    startupAccelSecondOrder,
   output logic      [2:0]    startupAccelFirstOrder,
   output logic      [4:0]    loopHandoverThreshold,
   output logic      [11:0]   handoverThresholdDhz,
   output logic      [2:0]    alignDuration,
   output logic               motorStationary,
   output logic               speedDetectActive,
   output logic               reverseDriveActive
);

   bmc_state_t st;
   bmc_state_t next_st;

   logic setupPhase;
   logic accessPhase;
   logic hit2;
   logic hit3;
   logic hit4;
   logic mapped;
   logic [`BMC_CNT_W-1:0] winCycles;

   // merge a write through the byte strobes; only lanes 0 and 1 carry bits
   function automatic logic [15:0] strobeWrite(input logic [15:0] old, input logic [15:0] mask,
                                               input logic [31:0] data, input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0])
      begin
         res[7:0] = data[7:0] & mask[7:0];
      end
      if (strb[1])
      begin
         res[15:8] = data[15:8] & mask[15:8];
      end
      return res;
   endfunction

   assign setupPhase  = psel & ~penable;
   assign accessPhase = psel & penable;
   // low two address bits must be zero: a misaligned access counts as unmapped
   assign hit2   = paddr == AW'({`BMC_CFG2_IDX, 2'h0});
   assign hit3   = paddr == AW'({`BMC_CFG3_IDX, 2'h0});
   assign hit4   = paddr == AW'({`BMC_CFG4_IDX, 2'h0});
   assign mapped = hit2 | hit3 | hit4;

   // window doubles with each code step, so one base count serves all four
   assign winCycles = `BMC_CNT_W'(STAT_WIN_CYC) << st.cfg3[`BMC_STAT_THR_F];

   always_comb
   begin
      logic [18:0] prod;
      logic [7:0]  margin;
      prod   = '0;
      margin = supplyLevel - bemfLevel;
      next_st = st;

      // read data is captured in the setup cycle and shown in the access cycle
      if (setupPhase)
      begin
         next_st.slverr = ~mapped;
         next_st.rdata  = 32'h0;
         if (hit2)
         begin
            next_st.rdata = {16'h0, st.cfg2 & `BMC_CFG2_MASK};
         end
         else if (hit3)
         begin
            next_st.rdata = {16'h0, st.cfg3};
         end
         else if (hit4)
         begin
            next_st.rdata = {16'h0, st.cfg4 & `BMC_CFG4_MASK};
         end
      end

      // fields change only on an accepted write and hold otherwise
      if (accessPhase && pwrite && mapped)
      begin
         if (hit2)
         begin
            next_st.cfg2 = strobeWrite(st.cfg2, `BMC_CFG2_MASK, pwdata, pstrb);
         end
         if (hit3)
         begin
            next_st.cfg3 = strobeWrite(st.cfg3, `BMC_CFG3_MASK, pwdata, pstrb);
         end
         if (hit4)
         begin
            next_st.cfg4 = strobeWrite(st.cfg4, `BMC_CFG4_MASK, pwdata, pstrb);
         end
      end

      next_st.emfConst = 11'(st.cfg2[`BMC_EMF_SIG_F]) << st.cfg2[`BMC_EMF_SHIFT_F];
      next_st.advTime  = 11'(st.cfg2[`BMC_ADV_VALUE_F]) << st.cfg2[`BMC_ADV_SHIFT_F];

      // combinational divide is cheap enough at 20 MHz and avoids a multi-cycle handshake
      if (!st.cfg2[`BMC_ADV_MODE_B])
      begin
         next_st.effAdvance = st.advTime;
      end
      else if (supplyLevel == 8'h00 || bemfLevel >= supplyLevel)
      begin
         next_st.effAdvance = 11'h000;
      end
      else
      begin
         prod = 19'(st.advTime) * 19'(margin);
         next_st.effAdvance = 11'(prod / 19'(supplyLevel));
      end

      if (st.cfg4[`BMC_HO_TOP_B])
      begin
         next_st.handover = (12'(st.cfg4[`BMC_HO_N_F]) + 12'h001) << `BMC_HO_HI_SHIFT;
      end
      else
      begin
         next_st.handover = 12'(st.cfg4[`BMC_HO_N_F]) << `BMC_HO_LO_SHIFT;
      end

      // stationary judgment: no zero crossing for a whole window while detection is on
      if (!st.cfg3[`BMC_DETECT_EN_B] || zeroCross)
      begin
         next_st.statCount  = '0;
         next_st.stationary = 1'b0;
      end
      else if (st.statCount >= winCycles - `BMC_CNT_W'(1))
      begin
         next_st.stationary = 1'b1;
      end
      else
      begin
         next_st.statCount = st.statCount + `BMC_CNT_W'(1);
      end

      next_st.detectActive = speedDetectRequest & st.cfg3[`BMC_DETECT_EN_B];
      next_st.revActive = reverseDriveRequest & st.cfg3[`BMC_REV_EN_B];
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st      <= '0;
         st.cfg2 <= `BMC_CFG_RESET;
         st.cfg3 <= `BMC_CFG_RESET;
         st.cfg4 <= `BMC_CFG_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // zero wait state: data was prepared in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = accessPhase & st.slverr;
   assign prdata  = st.rdata;

   assign emfConstant              = st.emfConst;
   assign advanceTime              = st.advTime;
   assign effectiveAdvance         = st.effAdvance;
   assign advanceModeSel           = st.cfg2[`BMC_ADV_MODE_B];
   assign stationaryJudgeThreshold = st.cfg3[`BMC_STAT_THR_F];
   assign brakeCurrentLevelSel     = st.cfg3[`BMC_BRK_LVL_B];
   assign comparatorHysteresisSel  = st.cfg3[`BMC_HYST_B];
   assign speedDetectEnable        = st.cfg3[`BMC_DETECT_EN_B];
   assign reverseDriveEnable       = st.cfg3[`BMC_REV_EN_B];
   assign reverseBrakeThreshold    = st.cfg3[`BMC_REV_THR_F];
   assign openloopAlignCurrent     = st.cfg3[`BMC_OL_CUR_F];
   assign openloopCurrentRamp      = st.cfg3[`BMC_OL_RAMP_F];
   assign brakeDoneTime            = st.cfg3[`BMC_BRK_TIME_F];
   assign brakeActiveFlag          = st.cfg3[`BMC_BRK_TIME_F] != 3'h0;
   assign accelRangeSelA           = st.cfg4[`BMC_ACC_RANGE_B];
   assign startupAccelSecondOrder  = st.cfg4[`BMC_ACC2_F];
   assign startupAccelFirstOrder   = st.cfg4[`BMC_ACC1_F];
   assign loopHandoverThreshold    = st.cfg4[`BMC_HO_F];
   assign handoverThresholdDhz     = st.handover;
   assign alignDuration            = st.cfg4[`BMC_ALIGN_F];
   assign motorStationary          = st.stationary;
   assign speedDetectActive        = st.detectActive;
   assign reverseDriveActive       = st.revActive;

   emf_const_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (accessPhase && pwrite && hit2 && pstrb[1:0] == 2'h3) |=> ##1
      (emfConstant == (11'($past(pwdata[11:8], 2)) << $past(pwdata[14:12], 2))))
      else $error("back-EMF constant does not follow written fields");

   adv_time_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (accessPhase && pwrite && hit2 && pstrb[0]) |=> ##1
      (advanceTime == (11'($past(pwdata[3:0], 2)) << $past(pwdata[6:4], 2))))
      else $error("advance time does not follow written fields");

   fixed_advance_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $past(!advanceModeSel) |-> (effectiveAdvance == $past(advanceTime)))
      else $error("fixed advance mode altered the advance time");

   scaled_advance_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $past(advanceModeSel && bemfLevel >= supplyLevel) |-> (effectiveAdvance == 11'h000))
      else $error("scaled advance not zero when back-EMF reaches supply");

   reserved_zero_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (accessPhase && !pwrite && (hit2 || hit4)) |-> (prdata[31:15] == 17'h0))
      else $error("reserved bits do not read as zero");

   stationary_gate_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(motorStationary) |-> ($past(speedDetectEnable) && $past(!zeroCross)))
      else $error("stationary flagged with detection off or a crossing seen");

   reverse_gate_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reverseDriveActive |-> $past(reverseDriveEnable && reverseDriveRequest))
      else $error("reverse drive applied while disabled");

   brake_disable_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (brakeDoneTime == 3'h0) |-> !brakeActiveFlag)
      else $error("braking active with brake code zero");

   unmapped_err_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (setupPhase && !mapped) |=> (penable |-> pslverr))
      else $error("unmapped access not answered with an error");

   field_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !(accessPhase && pwrite && hit3) |=> $stable(st.cfg3))
      else $error("speed detect register changed without a write");

   handover_low_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $past(!st.cfg4[`BMC_HO_TOP_B]) |-> (handoverThresholdDhz == 12'($past(st.cfg4[6:3])) * 12'h008))
      else $error("low-range handover threshold wrong");

   handover_high_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $past(st.cfg4[`BMC_HO_TOP_B]) |-> (handoverThresholdDhz == (12'($past(st.cfg4[6:3])) + 12'h001) * 12'h080))
      else $error("high-range handover threshold wrong");

   detect_gate_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      speedDetectActive |-> $past(speedDetectEnable && speedDetectRequest))
      else $error("speed detection active while disabled");

   detect_off_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !speedDetectEnable |=> !motorStationary)
      else $error("stationary flag kept with detection off");

   reverse_off_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !reverseDriveEnable |=> !reverseDriveActive)
      else $error("reverse drive kept after disable");

   write_lands_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (accessPhase && pwrite && hit3 && pstrb[1:0] == 2'h3) |=> (st.cfg3 == $past(pwdata[15:0])))
      else $error("full write to speed detect register did not land");

   read_data_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (accessPhase && !pwrite && hit3) |-> (prdata == {16'h0000, st.cfg3}))
      else $error("speed detect register read back wrong");

   error_source_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pslverr |-> $past(!mapped))
      else $error("error answered for a mapped address");

   unmapped_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (accessPhase && pwrite && !mapped) |=> ($stable(st.cfg2) && $stable(st.cfg3) && $stable(st.cfg4)))
      else $error("unmapped write changed a register");

endmodule

// ==== pkg/bmc_regs.svh ====
/*
 Register map, field ranges, reset values and timing counts of the motor configuration bank.
 Assumes a 20 MHz system clock and an APB word-addressed register window.
*/
`ifndef BMC_REGS_SVH
`define BMC_REGS_SVH

// register indices; byte address is four times the index
`define BMC_CFG2_IDX        10'h091
`define BMC_CFG3_IDX        10'h092
`define BMC_CFG4_IDX        10'h093

// writable bits; bit 15 of the first and last register is reserved
`define BMC_CFG2_MASK       16'h7fff
`define BMC_CFG3_MASK       16'hffff
`define BMC_CFG4_MASK       16'h7fff
`define BMC_CFG_RESET       16'h0000

// motor constant / advance register
`define BMC_EMF_SHIFT_F     14:12
`define BMC_EMF_SIG_F       11:8
`define BMC_ADV_MODE_B      7
`define BMC_ADV_SHIFT_F     6:4
`define BMC_ADV_VALUE_F     3:0

// speed detect / brake register
`define BMC_STAT_THR_F      15:14
`define BMC_BRK_LVL_B       13
`define BMC_HYST_B          12
`define BMC_DETECT_EN_B     11
`define BMC_REV_EN_B        10
`define BMC_REV_THR_F       9:8
`define BMC_OL_CUR_F        7:6
`define BMC_OL_RAMP_F       5:3
`define BMC_BRK_TIME_F      2:0

// start-up acceleration register
`define BMC_ACC_RANGE_B     14
`define BMC_ACC2_F          13:11
`define BMC_ACC1_F          10:8
`define BMC_HO_F            7:3
`define BMC_HO_TOP_B        7
`define BMC_HO_N_F          6:3
`define BMC_ALIGN_F         2:0

// handover threshold in 0.1 Hz units: 0.8 Hz steps or 12.8 Hz steps
`define BMC_HO_LO_SHIFT     3
`define BMC_HO_HI_SHIFT     7

// timing
`define BMC_CLK_HZ          20000000
`define BMC_STAT_WIN_MS     80
`define BMC_CNT_W           24

`endif

// ==== pkg/bmc_pkg.sv ====
/*
 Types of the motor configuration bank.
 Assumes the register header is reachable by bare name.
*/
`include "bmc_regs.svh"

package bmc_pkg;
   typedef struct packed {
      logic [15:0]            cfg2;
      logic [15:0]            cfg3;
      logic [15:0]            cfg4;
      logic [31:0]            rdata;
      logic                   slverr;
      logic [`BMC_CNT_W-1:0]  statCount;
      logic                   stationary;
      logic                   detectActive;
      logic                   revActive;
      logic [10:0]            emfConst;
      logic [10:0]            advTime;
      logic [10:0]            effAdvance;
      logic [11:0]            handover;
   } bmc_state_t;
endpackage

// ==== verif/bmc_config_regs_tb.sv ====
/*
 Self-checking bench of the motor configuration bank: APB register access, field decode, derived values.
 Assumes the register header and package are compiled first; the stationary window is shortened to 16 cycles.
*/
`include "bmc_regs.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module bmc_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bmc_pkg::*;
   localparam int WIN = 16;
   logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic        zeroCross, speedDetectRequest, reverseDriveRequest, er;
   logic [7:0]  supplyLevel, bemfLevel;
   logic [10:0] emfConstant, advanceTime, effectiveAdvance;
   logic        advanceModeSel, brakeCurrentLevelSel, comparatorHysteresisSel, speedDetectEnable;
   logic        reverseDriveEnable, brakeActiveFlag, accelRangeSelA, motorStationary;
   logic        speedDetectActive, reverseDriveActive;
   logic [1:0]  stationaryJudgeThreshold, reverseBrakeThreshold, openloopAlignCurrent;
   logic [2:0]  openloopCurrentRamp, brakeDoneTime, startupAccelSecondOrder, startupAccelFirstOrder, alignDuration;
   logic [4:0]  loopHandoverThreshold;
   logic [11:0] handoverThresholdDhz;
   int          errors, n_tests;
   localparam logic [11:0] A2 = 12'h244, A3 = 12'h248, A4 = 12'h24c;

   bmc_config_regs #(.AW(12), .STAT_WIN_CYC(WIN)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .zeroCross(zeroCross), .speedDetectRequest(speedDetectRequest),
      .reverseDriveRequest(reverseDriveRequest), .supplyLevel(supplyLevel), .bemfLevel(bemfLevel),
      .emfConstant(emfConstant), .advanceTime(advanceTime), .effectiveAdvance(effectiveAdvance),
      .advanceModeSel(advanceModeSel), .stationaryJudgeThreshold(stationaryJudgeThreshold),
      .brakeCurrentLevelSel(brakeCurrentLevelSel), .comparatorHysteresisSel(comparatorHysteresisSel),
      .speedDetectEnable(speedDetectEnable), .reverseDriveEnable(reverseDriveEnable),
      .reverseBrakeThreshold(reverseBrakeThreshold), .openloopAlignCurrent(openloopAlignCurrent),
      .openloopCurrentRamp(openloopCurrentRamp), .brakeDoneTime(brakeDoneTime), .brakeActiveFlag(brakeActiveFlag),
      .accelRangeSelA(accelRangeSelA), .startupAccelSecondOrder(startupAccelSecondOrder),
      .startupAccelFirstOrder(startupAccelFirstOrder), .loopHandoverThreshold(loopHandoverThreshold),
      .handoverThresholdDhz(handoverThresholdDhz), .alignDuration(alignDuration),
      .motorStationary(motorStationary), .speedDetectActive(speedDetectActive),
      .reverseDriveActive(reverseDriveActive));

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic summarize();
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // one transfer; request held until pready is sampled high, answer taken at that edge
   task automatic apb(input logic [11:0] a, input logic wr, input logic [15:0] d, input logic [3:0] s);
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {16'h0000, d}; pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic settle();
      repeat (6) @(posedge clk_sys);
      #1;
   endtask

   task automatic t_reset_and_mask();
      logic [11:0] ad[3];
      logic [31:0] msk[3];
      ad = '{A2, A3, A4};
      msk = '{{16'h0000, `BMC_CFG2_MASK}, {16'h0000, `BMC_CFG3_MASK}, {16'h0000, `BMC_CFG4_MASK}};
      for (int i = 0; i < 3; i++)
      begin
         apb(ad[i], 1'b0, 16'h0000, 4'h0);
         `CHK("reset value", 32'h0, rd)
         apb(ad[i], 1'b1, msk[i][15:0], 4'hf);
         apb(ad[i], 1'b0, 16'h0000, 4'h0);
         `CHK("writable bits", msk[i], rd)
         `CHK("no error", 1'b0, er)
      end
      apb(12'h250, 1'b1, 16'h1234, 4'hf);
      `CHK("unmapped write error", 1'b1, er)
      apb(12'h245, 1'b0, 16'h0000, 4'h0);
      `CHK("misaligned read error", 1'b1, er)
      `CHK("misaligned read data", 32'h0, rd)
      apb(A3, 1'b0, 16'h0000, 4'h0);
      `CHK("unmapped write ignored", 32'hffff, rd)
   endtask

   task automatic t_emf_advance();
      supplyLevel <= 8'd200; bemfLevel <= 8'd100;
      apb(A2, 1'b1, 16'h3f25, 4'h3);
      settle();
      `CHK("emf constant", 11'h078, emfConstant)
      `CHK("advance time", 11'h014, advanceTime)
      `CHK("fixed advance", 11'h014, effectiveAdvance)
      apb(A2, 1'b1, 16'h00ff, 4'h1);
      settle();
      `CHK("emf kept on lane write", 11'h078, emfConstant)
      `CHK("advance time max shift", 11'h780, advanceTime)
      `CHK("mode select", 1'b1, advanceModeSel)
      `CHK("scaled advance", 11'd960, effectiveAdvance)
      bemfLevel <= 8'd250;
      settle();
      `CHK("scaled advance floor", 11'd0, effectiveAdvance)
      apb(A2, 1'b0, 16'h0000, 4'h0);
      `CHK("merged register", 32'h3fff, rd)
   endtask

   task automatic t_cfg3_codes();
      logic [15:0] v;
      for (int i = 0; i < 8; i++)
      begin
         v = (16'(i % 4) << 14) | (16'(i % 2) << 13) | (16'(i / 4) << 12) | (16'(i % 4) << 8)
             | (16'(i % 4) << 6) | (16'(i) << 3) | 16'(7 - i);
         apb(A3, 1'b1, v, 4'h3);
         settle();
         `CHK("stationary code", 2'(i % 4), stationaryJudgeThreshold)
         `CHK("brake level", 1'(i % 2), brakeCurrentLevelSel)
         `CHK("hysteresis", 1'(i / 4), comparatorHysteresisSel)
         `CHK("reverse threshold", 2'(i % 4), reverseBrakeThreshold)
         `CHK("current code", 2'(i % 4), openloopAlignCurrent)
         `CHK("ramp code", 3'(i), openloopCurrentRamp)
         `CHK("brake time", 3'(7 - i), brakeDoneTime)
         `CHK("brake active", (i != 7), brakeActiveFlag)
      end
   endtask

   task automatic t_enables();
      speedDetectRequest <= 1'b1; reverseDriveRequest <= 1'b1;
      apb(A3, 1'b1, 16'h0000, 4'h3);
      settle();
      `CHK("detect refused", 1'b0, speedDetectActive)
      `CHK("reverse refused", 1'b0, reverseDriveActive)
      apb(A3, 1'b1, 16'h0c00, 4'h3);
      settle();
      `CHK("detect enable", 1'b1, speedDetectEnable)
      `CHK("reverse enable", 1'b1, reverseDriveEnable)
      `CHK("detect active", 1'b1, speedDetectActive)
      `CHK("reverse active", 1'b1, reverseDriveActive)
      speedDetectRequest <= 1'b0; reverseDriveRequest <= 1'b0;
   endtask

   task automatic t_stationary(input int code);
      apb(A3, 1'b1, 16'(code) << 14 | 16'h0800, 4'h3);
      @(posedge clk_sys) zeroCross <= 1'b1;
      @(posedge clk_sys) zeroCross <= 1'b0;
      repeat ((WIN << code) - 4) @(posedge clk_sys);
      #1;
      `CHK("not yet stationary", 1'b0, motorStationary)
      repeat (8) @(posedge clk_sys);
      #1;
      `CHK("stationary", 1'b1, motorStationary)
      apb(A3, 1'b1, 16'h0000, 4'h3);
      settle();
      `CHK("stationary off", 1'b0, motorStationary)
   endtask

   task automatic t_cfg4();
      logic [4:0]  ho[4];
      logic [11:0] dhz[4];
      ho = '{5'h00, 5'h0f, 5'h10, 5'h1f};
      dhz = '{12'd0, 12'd120, 12'd128, 12'd2048};
      for (int i = 0; i < 4; i++)
      begin
         apb(A4, 1'b1, (16'(i % 2) << 14) | (16'(i) << 11) | (16'(7 - i) << 8) | (16'(ho[i]) << 3) | 16'(i), 4'h3);
         settle();
         `CHK("range select", 1'(i % 2), accelRangeSelA)
         `CHK("accel second", 3'(i), startupAccelSecondOrder)
         `CHK("accel first", 3'(7 - i), startupAccelFirstOrder)
         `CHK("handover code", ho[i], loopHandoverThreshold)
         `CHK("handover value", dhz[i], handoverThresholdDhz)
         `CHK("align code", 3'(i), alignDuration)
      end
   endtask

   initial
   begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0; pstrb = '0;
      zeroCross = 1'b0; speedDetectRequest = 1'b0; reverseDriveRequest = 1'b0;
      supplyLevel = 8'd0; bemfLevel = 8'd0; errors = 0; n_tests = 0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset_and_mask();
      t_emf_advance();
      t_cfg3_codes();
      t_enables();
      t_stationary(0);
      t_stationary(1);
      t_cfg4();
      summarize();
   end

   // the whole sequence needs well under two thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      summarize();
   end
endmodule
